//--- verilog/ups_ctrl.sv
// Fault and power sequencing logic for a dual USB port power switch.
//
// Function
// - Undervoltage keeps switch off, channels inactive.
// - Disabled switch blocks reverse output current.
// - Start-up passes constant limited current.
// - Fault flag blanked until transistor enhanced.
// - Overcurrent enters current limiting mode immediately.
// - Four rating options, trip level above.
// - Limit lasts about twelve milliseconds.
// - Limit timer starts at limiting, temperature-independent.
// - Still limiting at expiry: off, fault low.
// - Latch-off holds output, fault until disable.
// - Disable releases fault; host re-enables.
// - Auto-restart retries about once per second.
// - Persistent overcurrent keeps fault, retries; heat lengthens. Here the flag clears each time a retry reaches UPS_ON.
// - Lower thermal threshold blocks switch turn-on.
// - Upper threshold turns off; release when cooled.
// - Disabled channel engages output pull-down.
// - Power-on preset clears latch and fault.
// - Turn on only if enabled and supply good.
// - Selectable enable polarity; undriven means deasserted.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "ups_params.svh"

module ups_ctrl #(
  parameter int LIMIT_CYCLES = `UPS_LIMIT_MS * (`UPS_CLK_HZ / `UPS_HZ_PER_KHZ),
  parameter int RETRY_CYCLES = `UPS_RETRY_S * `UPS_CLK_HZ
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave.
  input wire logic [`UPS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Shared analog indications.
  input wire logic supply_below_uvlo,
  input wire logic temp_above_lower,
  input wire logic temp_above_upper,
  input wire logic temp_below_release,
  // Per-channel pins and analog indications.
  input wire logic [1:0] enable_pin,
  input wire logic [1:0] overcurrent_condition,
  input wire logic [1:0] fet_enhanced,
  // Per-channel switch controls.
  output logic [1:0] switch_on,
  output logic [1:0] current_limit_mode,
  output logic [1:0] output_pulldown,
  output logic [1:0] reverse_block,
  output logic [1:0] fault_n,
  // Selected continuous current rating code for the trip comparator.
  output logic [1:0] limit_current_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Timing end counts.

  localparam logic [`UPS_CNT_W-1:0] LIM_END = `UPS_CNT_W'(LIMIT_CYCLES - 1);
  localparam logic [`UPS_CNT_W-1:0] RTY_END = `UPS_CNT_W'(RETRY_CYCLES - 1);
  localparam logic [`UPS_CNT_W-1:0] CNT_ONE = `UPS_CNT_W'(1);

  ups_pkg::ups_state_t s_q;
  ups_pkg::ups_state_t s_d;
  ups_pkg::ups_ch_t ch_nx [2];

  logic retry_mode;
  logic en_low;
  logic therm_block;
  logic [1:0] en;

  assign retry_mode = s_q.cfg[`UPS_CFG_RETRY_BIT];
  assign en_low = s_q.cfg[`UPS_CFG_ENLOW_BIT];
  // Turn-on is refused from the lower threshold, and while the shutdown holds.
  assign therm_block = temp_above_lower | s_q.hot;

  ////////////////////////////////////////////////////////////////////////////
  // Channel sequencers.

  // Each channel has its own timer, latch and flag; a shared counter would
  // let one shorted port hold the other off.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // A floating enable pin is pulled to its deasserted level outside.
      assign en[gi] = enable_pin[gi] ^ en_low;

      always_comb begin
        ch_nx[gi] = s_q.ch[gi];
        unique case (s_q.ch[gi].st)
          ups_pkg::UPS_OFF: begin
            ch_nx[gi].tmr = '0;
            if (en[gi] && !supply_below_uvlo && !therm_block) begin
              ch_nx[gi].st = ups_pkg::UPS_START;
            end
          end
          ups_pkg::UPS_START: begin
            // The flag is only raised from a timed trip, so start-up never sets it.
            if (fet_enhanced[gi]) begin
              ch_nx[gi].st = ups_pkg::UPS_ON;
            end
          end
          ups_pkg::UPS_ON: begin
            // A retry that reaches full enhancement clears the flag again.
            ch_nx[gi].fault = 1'b0;
            if (overcurrent_condition[gi]) begin
              ch_nx[gi].st = ups_pkg::UPS_LIMIT;
              ch_nx[gi].tmr = '0;
            end
          end
          ups_pkg::UPS_LIMIT: begin
            if (!overcurrent_condition[gi]) begin
              ch_nx[gi].st = ups_pkg::UPS_ON;
              ch_nx[gi].tmr = '0;
            end else if (s_q.ch[gi].tmr == LIM_END) begin
              ch_nx[gi].st = ups_pkg::UPS_TRIP;
              ch_nx[gi].fault = 1'b1;
              ch_nx[gi].tmr = '0;
            end else begin
              ch_nx[gi].tmr = s_q.ch[gi].tmr + CNT_ONE;
            end
          end
          ups_pkg::UPS_TRIP: begin
            if (!en[gi]) begin
              ch_nx[gi].st = ups_pkg::UPS_OFF;
              ch_nx[gi].fault = 1'b0;
            end else if (retry_mode) begin
              // Holding the count while hot stretches the retry period.
              if (s_q.ch[gi].tmr != RTY_END) begin
                ch_nx[gi].tmr = s_q.ch[gi].tmr + CNT_ONE;
              end else if (!therm_block) begin
                ch_nx[gi].st = ups_pkg::UPS_START;
                ch_nx[gi].tmr = '0;
              end
            end
          end
        endcase
        // Disable, shutdown and undervoltage take priority over the sequence.
        if (s_q.ch[gi].st != ups_pkg::UPS_TRIP && s_q.ch[gi].st != ups_pkg::UPS_OFF) begin
          if (!en[gi] || s_q.hot) begin
            ch_nx[gi].st = ups_pkg::UPS_OFF;
            ch_nx[gi].fault = 1'b0;
          end
        end
        if (supply_below_uvlo) begin
          ch_nx[gi].st = ups_pkg::UPS_OFF;
          ch_nx[gi].fault = 1'b0;
          ch_nx[gi].tmr = '0;
        end
        // Pin flops follow the next state so the pins change with the state.
        ch_nx[gi].sw_on = ch_nx[gi].st == ups_pkg::UPS_START ||
                          ch_nx[gi].st == ups_pkg::UPS_ON ||
                          ch_nx[gi].st == ups_pkg::UPS_LIMIT;
        ch_nx[gi].lim = ch_nx[gi].st == ups_pkg::UPS_START ||
                        ch_nx[gi].st == ups_pkg::UPS_LIMIT;
        ch_nx[gi].pd = !ch_nx[gi].sw_on;
        ch_nx[gi].rb = !ch_nx[gi].sw_on;
        ch_nx[gi].flt_n = !ch_nx[gi].fault;
      end

      assign switch_on[gi] = s_q.ch[gi].sw_on;
      assign current_limit_mode[gi] = s_q.ch[gi].lim;
      assign output_pulldown[gi] = s_q.ch[gi].pd;
      assign reverse_block[gi] = s_q.ch[gi].rb;
      assign fault_n[gi] = s_q.ch[gi].flt_n;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Shared state and register slave.

  always_comb begin
    s_d = s_q;
    s_d.ch[0] = ch_nx[0];
    s_d.ch[1] = ch_nx[1];
    // Shutdown sets at the upper threshold and holds until cooled.
    if (temp_above_upper) begin
      s_d.hot = 1'b1;
    end else if (temp_below_release) begin
      s_d.hot = 1'b0;
    end
    // One wait state: the answer comes in the cycle after the request.
    s_d.wreq = 1'b1;
    if ((avs_read || avs_write) && s_q.wreq) begin
      s_d.wreq = 1'b0;
      s_d.rdata = '0;
      if (avs_read && avs_address == `UPS_REG_CFG) begin
        s_d.rdata[`UPS_CFG_W-1:0] = s_q.cfg;
      end else if (avs_read && avs_address == `UPS_REG_STAT) begin
        s_d.rdata[`UPS_STAT_ST0_LSB +: $bits(ups_pkg::ups_ch_st_t)] = s_q.ch[0].st;
        s_d.rdata[`UPS_STAT_ST1_LSB +: $bits(ups_pkg::ups_ch_st_t)] = s_q.ch[1].st;
        s_d.rdata[`UPS_STAT_FLT_LSB] = s_q.ch[0].fault;
        s_d.rdata[`UPS_STAT_FLT_LSB + 1] = s_q.ch[1].fault;
        s_d.rdata[`UPS_STAT_UV_BIT] = supply_below_uvlo;
        s_d.rdata[`UPS_STAT_HOT_BIT] = s_q.hot;
      end
    end
    // The write lands at the edge where waitrequest is seen low.
    if (avs_write && !s_q.wreq && avs_address == `UPS_REG_CFG && avs_byteenable[0]) begin
      s_d.cfg = avs_writedata[`UPS_CFG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.ch[0] <= '{st: ups_pkg::UPS_OFF, tmr: '0, fault: 1'b0, sw_on: 1'b0,
                     lim: 1'b0, pd: 1'b1, rb: 1'b1, flt_n: 1'b1};
      s_q.ch[1] <= '{st: ups_pkg::UPS_OFF, tmr: '0, fault: 1'b0, sw_on: 1'b0,
                     lim: 1'b0, pd: 1'b1, rb: 1'b1, flt_n: 1'b1};
      s_q.hot <= 1'b0;
      s_q.cfg <= `UPS_CFG_RST;
      s_q.wreq <= 1'b1;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = s_q.wreq;
  assign avs_readdata = s_q.rdata;
  // The analog trip comparator sits above the rating this code selects.
  assign limit_current_level = s_q.cfg[`UPS_CFG_RATE_MSB:`UPS_CFG_RATE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_hot_sets;
    temp_above_upper |=> s_q.hot;
  endproperty
  a_hot_sets: assert property (p_hot_sets) else $error("shutdown not set");

  property p_hot_holds;
    s_q.hot && !temp_below_release |=> s_q.hot;
  endproperty
  a_hot_holds: assert property (p_hot_holds) else $error("shutdown left early");

  property p_cfg_write;
    avs_write && !avs_waitrequest && avs_address == `UPS_REG_CFG && avs_byteenable[0]
      |=> limit_current_level == $past(avs_writedata[`UPS_CFG_RATE_MSB:`UPS_CFG_RATE_LSB]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("rating code wrong");

  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no bus answer");

  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("bus answer too long");

  generate
    for (gi = 0; gi < 2; gi++) begin : g_chk
      property p_uvlo_off;
        supply_below_uvlo |=> !switch_on[gi] && fault_n[gi];
      endproperty
      a_uvlo_off: assert property (p_uvlo_off) else $error("on under uvlo");

      property p_rev_pd;
        !switch_on[gi] |-> reverse_block[gi] && output_pulldown[gi];
      endproperty
      a_rev_pd: assert property (p_rev_pd) else $error("off without block");

      property p_soft;
        $rose(switch_on[gi]) |-> current_limit_mode[gi];
      endproperty
      a_soft: assert property (p_soft) else $error("start not limited");

      property p_blank;
        s_q.ch[gi].st == ups_pkg::UPS_START && fault_n[gi] |=> fault_n[gi];
      endproperty
      a_blank: assert property (p_blank) else $error("fault during start");

      property p_oc;
        s_q.ch[gi].st == ups_pkg::UPS_ON && overcurrent_condition[gi] && en[gi] &&
          !s_q.hot && !supply_below_uvlo |=> current_limit_mode[gi] && switch_on[gi];
      endproperty
      a_oc: assert property (p_oc) else $error("no limit on overcurrent");

      property p_trip;
        s_q.ch[gi].st == ups_pkg::UPS_LIMIT && s_q.ch[gi].tmr == LIM_END &&
          overcurrent_condition[gi] && en[gi] && !s_q.hot && !supply_below_uvlo
          |=> !switch_on[gi] && !fault_n[gi];
      endproperty
      a_trip: assert property (p_trip) else $error("no trip at limit end");

      property p_tmr_cap;
        s_q.ch[gi].st == ups_pkg::UPS_LIMIT |-> s_q.ch[gi].tmr <= LIM_END;
      endproperty
      a_tmr_cap: assert property (p_tmr_cap) else $error("limit timer overran");

      property p_latch;
        s_q.ch[gi].st == ups_pkg::UPS_TRIP && !retry_mode && en[gi] && !supply_below_uvlo
          |=> !switch_on[gi] && !fault_n[gi];
      endproperty
      a_latch: assert property (p_latch) else $error("latch released");

      property p_release;
        s_q.ch[gi].st == ups_pkg::UPS_TRIP && !en[gi] |=> fault_n[gi] && !switch_on[gi];
      endproperty
      a_release: assert property (p_release) else $error("fault not released");

      property p_retry;
        s_q.ch[gi].st == ups_pkg::UPS_TRIP && retry_mode && en[gi] &&
          s_q.ch[gi].tmr == RTY_END && !therm_block && !supply_below_uvlo
          |=> switch_on[gi] && !fault_n[gi];
      endproperty
      a_retry: assert property (p_retry) else $error("no retry");

      property p_therm_block;
        !switch_on[gi] && therm_block |=> !switch_on[gi];
      endproperty
      a_therm_block: assert property (p_therm_block) else $error("on while hot");

      property p_en_on;
        $rose(switch_on[gi]) |-> $past(en[gi]) && !$past(supply_below_uvlo);
      endproperty
      a_en_on: assert property (p_en_on) else $error("on without enable");

      property p_pd_on;
        switch_on[gi] |-> !output_pulldown[gi] && !reverse_block[gi];
      endproperty
      a_pd_on: assert property (p_pd_on) else $error("pull-down while on");

      property p_retry_wait;
        s_q.ch[gi].st == ups_pkg::UPS_TRIP && retry_mode && en[gi] &&
          s_q.ch[gi].tmr != RTY_END && !supply_below_uvlo |=> !switch_on[gi];
      endproperty
      a_retry_wait: assert property (p_retry_wait) else $error("retry too early");

      // The flag may only fall out of a timed limit, never out of start-up.
      property p_fault_src;
        $fell(fault_n[gi]) |-> $past(s_q.ch[gi].st) == ups_pkg::UPS_LIMIT;
      endproperty
      a_fault_src: assert property (p_fault_src) else $error("fault without trip");
    end
  endgenerate

endmodule

//--- verilog/ups_params.svh
// Constants for the dual USB port switch fault controller.
`ifndef UPS_PARAMS_SVH
`define UPS_PARAMS_SVH

// Timebase and protection timing.
`define UPS_CLK_HZ 25000000
`define UPS_HZ_PER_KHZ 1000
`define UPS_LIMIT_MS 12
`define UPS_RETRY_S 1
`define UPS_CNT_W 25

// Register byte addresses on the slave port.
`define UPS_ADDR_W 4
`define UPS_REG_CFG 4'h0
`define UPS_REG_STAT 4'h4

// Configuration field positions and reset value.
`define UPS_CFG_RATE_LSB 0
`define UPS_CFG_RATE_MSB 1
`define UPS_CFG_RETRY_BIT 2
`define UPS_CFG_ENLOW_BIT 3
`define UPS_CFG_RST 4'h0
`define UPS_CFG_W 4

// Status field positions.
`define UPS_STAT_ST0_LSB 0
`define UPS_STAT_ST1_LSB 3
`define UPS_STAT_FLT_LSB 6
`define UPS_STAT_UV_BIT 8
`define UPS_STAT_HOT_BIT 9

`endif

//--- verilog/ups_pkg.sv
// Types shared by the port switch fault controller.
`include "ups_params.svh"

package ups_pkg;

  // Per-channel sequencer states.
  typedef enum logic [2:0] {
    UPS_OFF,
    UPS_START,
    UPS_ON,
    UPS_LIMIT,
    UPS_TRIP
  } ups_ch_st_t;

  // Per-channel state, including the flops that drive the pins.
  typedef struct packed {
    ups_ch_st_t st;
    logic [`UPS_CNT_W-1:0] tmr;
    logic fault;
    logic sw_on;
    logic lim;
    logic pd;
    logic rb;
    logic flt_n;
  } ups_ch_t;

  // Whole module state.
  typedef struct packed {
    ups_ch_t [1:0] ch;
    logic hot;
    logic [`UPS_CFG_W-1:0] cfg;
    logic wreq;
    logic [31:0] rdata;
  } ups_state_t;

endpackage

//--- dv/ups_host_model.sv
// Host model that drives the two enable pins or leaves them to the pull.
`timescale 1ns/10ps

module ups_host_model (
  // Host requests.
  input wire logic [1:0] want,
  input wire logic [1:0] drive,
  input wire logic active_low,
  // Enable pins.
  output logic [1:0] enable_pin
);
  // An undriven pin rests at the pull level, which is always the deasserted level.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      enable_pin[i] = drive[i] ? (want[i] ^ active_low) : active_low;
    end
  end
endmodule

//--- dv/tb_top.sv
// Self-checking testbench for the port switch fault controller.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_top;
  localparam int LC = 20;
  localparam int RC = 50;
  logic clk, rst_n, rd, wr, uv, tlo, thi, trel, pol, wreq;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, q, lf;
  logic [1:0] want, drive, en, oc, fet, sw, lim, pd, rb, flt, lvl;
  int n_mismatch, compares;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ups_host_model ups_host_model_i (.want(want), .drive(drive), .active_low(pol), .enable_pin(en));
  ups_ctrl #(.LIMIT_CYCLES(LC), .RETRY_CYCLES(RC)) ups_ctrl_i (
    .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .supply_below_uvlo(uv), .temp_above_lower(tlo),
    .temp_above_upper(thi), .temp_below_release(trel), .enable_pin(en),
    .overcurrent_condition(oc), .fet_enhanced(fet), .switch_on(sw), .current_limit_mode(lim),
    .output_pulldown(pd), .reverse_block(rb), .fault_n(flt), .limit_current_level(lvl));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request stays put until waitrequest is seen low; one idle edge follows it.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    i = 0;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      i++;
      if (i > 20) begin
        n_mismatch++;
        summarize();
      end
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_sw(input int ch, input logic v, input int n);
    int i;
    i = 0;
    while (sw[ch] !== v) begin
      i++;
      if (i > n) begin
        n_mismatch++;
        summarize();
      end
      @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rd, wr, uv, tlo, thi, pol, rst_n} = '0;
    {addr, wdata, want, drive, oc, fet} = '0;
    trel = 1'b1;
    be = 4'hf;
    n_mismatch = 0;
    compares = 0;
    lf = 32'h081a;
    cyc(4);
    rst_n <= 1'b1;
    cyc(2);
    `CHK("reset pins", 10'h03f, {sw, lim, pd, rb, flt})
    bus(1'b0, 4'h0, 32'h0);
    `CHK("config reset", 32'h0, q)
    bus(1'b0, 4'hc, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      bus(1'b1, 4'h0, {lf[31:4], 2'b00, 2'(k)});
      cyc(1);
      `CHK("rating level", 2'(k), lvl)
      bus(1'b0, 4'h0, 32'h0);
      `CHK("config readback", {30'h0, 2'(k)}, q)
    end
    // Lane 0 off and a status write must both leave the configuration alone.
    be <= 4'he;
    bus(1'b1, 4'h0, 32'h0);
    be <= 4'hf;
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    `CHK("refused writes", 32'h3, q)
    bus(1'b1, 4'h0, 32'h0);
    // Latch-off: start, limit, trip, hold, release.
    drive <= 2'b11;
    want <= 2'b01;
    cyc(2);
    `CHK("start ch0", 4'b1101, {sw[0], lim[0], pd[0], flt[0]})
    `CHK("ch1 idle", 1'b0, sw[1])
    fet <= 2'b11;
    cyc(2);
    `CHK("enhanced", 1'b0, lim[0])
    oc <= 2'b01;
    cyc(2);
    `CHK("limit entered", 1'b1, lim[0])
    cyc(LC - 1);
    `CHK("limit held", 1'b1, sw[0])
    cyc(1);
    `CHK("tripped", 4'b0011, {sw[0], flt[0], pd[0], rb[0]})
    `CHK("ch1 fault", 1'b1, flt[1])
    oc <= 2'b00;
    cyc(RC + 5);
    `CHK("latched", 2'b00, {sw[0], flt[0]})
    bus(1'b0, 4'h4, 32'h0);
    `CHK("status", {1'b1, 3'(ups_pkg::UPS_TRIP)}, {q[6], q[2:0]})
    want <= 2'b00;
    cyc(2);
    `CHK("fault released", 1'b1, flt[0])
    want <= 2'b01;
    cyc(2);
    `CHK("re-enabled", 1'b1, sw[0])
    oc <= 2'b01;
    cyc(LC + 3);
    `CHK("tripped again", 1'b0, flt[0])
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    `CHK("preset clears", 2'b11, flt)
    want <= 2'b00;
    oc <= 2'b00;
    uv <= 1'b1;
    cyc(2);
    want <= 2'b11;
    cyc(4);
    `CHK("undervoltage off", 2'b00, sw)
    uv <= 1'b0;
    wait_sw(0, 1'b1, 4);
    want <= 2'b01;
    cyc(3);
    // Thermal: lower blocks turn-on, upper turns off, release on cooling.
    tlo <= 1'b1;
    trel <= 1'b0;
    want <= 2'b11;
    cyc(4);
    `CHK("lower blocks", 2'b01, sw)
    thi <= 1'b1;
    cyc(3);
    `CHK("upper off", 2'b00, sw)
    thi <= 1'b0;
    tlo <= 1'b0;
    cyc(5);
    `CHK("hysteresis", 2'b00, sw)
    trel <= 1'b1;
    wait_sw(0, 1'b1, 4);
    `CHK("cooled", 2'b11, sw)
    want <= 2'b00;
    cyc(2);
    // Auto-retry on channel 1.
    bus(1'b1, 4'h0, 32'h4);
    want <= 2'b10;
    cyc(3);
    oc <= 2'b10;
    cyc(LC + 2);
    `CHK("retry trip", 2'b00, {sw[1], flt[1]})
    cyc(RC - 3);
    `CHK("retry wait", 1'b0, sw[1])
    wait_sw(1, 1'b1, 8);
    `CHK("retry fault kept", 2'b01, {flt[1], flt[0]})
    oc <= 2'b00;
    cyc(4);
    `CHK("retry recovered", 1'b1, flt[1])
    want <= 2'b00;
    // Active-low enable and the undriven pin.
    pol <= 1'b1;
    drive <= 2'b00;
    bus(1'b1, 4'h0, 32'h8);
    cyc(3);
    `CHK("undriven off", 2'b00, sw)
    drive <= 2'b01;
    want <= 2'b01;
    cyc(3);
    `CHK("low enable", 3'b001, {en[0], sw})
    summarize();
  end
endmodule
